// File: cdoc_pkg.sv
package cdoc_pkg;
  // Channel count and datapath widths
  localparam int NCH = 9;
  localparam int CMD_W = 11;
  localparam int CMD_SHIFT = 10;
  localparam logic [10:0] CMD_FULL = 11'h400;
  localparam int CUR_W = 12;
  localparam int VOLT_W = 10;
  localparam int DUTY_W = 10;
  localparam int SP_W = 13;
  localparam int GAIN_W = 10;
  localparam int GAIN_SHIFT = 10;
  localparam int ADDR_W = 12;
  localparam logic [9:0] PWM_MAX = 10'h3e8;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int DITHER_STEP_MS = 2;
  localparam int DITHER_AMT_STEP_MA = 10;
  localparam int TIMEOUT_STEP_MS = 4;
  localparam logic [4:0] OFF_SETTLE = 5'h10;

  // Global register byte offsets
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_CLEAR = 12'h004;
  localparam logic [11:0] REG_IRQ_EN = 12'h008;
  localparam logic [11:0] REG_TIMEOUT = 12'h00c;
  localparam logic [11:0] REG_LIVE = 12'h010;

  // Per-channel word index inside a 64-byte block at 0x40 * (channel + 1)
  localparam logic [3:0] CH_MODE = 4'h0;
  localparam logic [3:0] CH_CMD = 4'h1;
  localparam logic [3:0] CH_MAX_CUR = 4'h2;
  localparam logic [3:0] CH_MIN_CUR = 4'h3;
  localparam logic [3:0] CH_VLIM = 4'h4;
  localparam logic [3:0] CH_PWM_LIM = 4'h5;
  localparam logic [3:0] CH_DPERIOD = 4'h6;
  localparam logic [3:0] CH_DAMOUNT = 4'h7;
  localparam logic [3:0] CH_KP = 4'h8;
  localparam logic [3:0] CH_KI = 4'h9;
  localparam logic [3:0] CH_RUP = 4'ha;
  localparam logic [3:0] CH_RDN = 4'hb;
  localparam logic [3:0] CH_DUTY = 4'hc;

  // Status layout: bits 8..0 open load per channel, bit 9 command timeout
  localparam int ST_W = 10;
  localparam int ST_TIMEOUT_BIT = 9;

  // Reset values
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [11:0] RST_MAX_CUR = 12'h3e8;
  localparam logic [11:0] RST_MIN_CUR = 12'h000;
  localparam logic [9:0] RST_VLIM = 10'h000;
  localparam logic [9:0] RST_PWM_LIM = 10'h3e8;
  localparam logic [6:0] RST_DPERIOD = 7'h02;
  localparam logic [5:0] RST_DAMOUNT = 6'h00;
  localparam logic [9:0] RST_KP = 10'h064;
  localparam logic [9:0] RST_KI = 10'h00a;
  localparam logic [9:0] RST_RAMP = 10'h064;
  localparam logic [7:0] RST_TIMEOUT = 8'h00;

  // Operation mode codes
  localparam logic [1:0] MODE_DIGITAL = 2'h0;
  localparam logic [1:0] MODE_CURRENT = 2'h1;
  localparam logic [1:0] MODE_VOLTAGE = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam logic [2:0] MODE_UNUSED = 3'h4;

  typedef enum logic [1:0] {
    TO_IDLE = 2'b00,
    TO_RUN = 2'b01,
    TO_FAULT = 2'b11
  } cdoc_to_state_t;
endpackage : cdoc_pkg

// File: cdoc_loop_if.sv
`timescale 1ns/1ps
interface cdoc_loop_if;
  import cdoc_pkg::*;
  logic en;
  logic closed_loop;
  logic [SP_W-1:0] sp;
  logic [SP_W-1:0] fb;
  logic [GAIN_W-1:0] kp;
  logic [GAIN_W-1:0] ki;
  logic [DUTY_W-1:0] lim;
  logic [DUTY_W-1:0] open_duty;
  logic [DUTY_W-1:0] duty;
  logic drive;
  modport ctl(output en, closed_loop, sp, fb, kp, ki, lim, open_duty, input duty, drive);
  modport loop(input en, closed_loop, sp, fb, kp, ki, lim, open_duty, output duty, drive);
endinterface : cdoc_loop_if

// File: cdoc_pi_pwm.sv
`timescale 1ns/1ps
module cdoc_pi_pwm (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Setpoint in, drive out
  cdoc_loop_if.loop lp
);
  import cdoc_pkg::*;

  logic [DUTY_W-1:0] cnt_q;
  logic [DUTY_W-1:0] duty_q;
  logic drive_q;
  logic signed [25:0] integ_q;
  logic signed [13:0] err;
  logic signed [10:0] kp_s;
  logic signed [10:0] ki_s;
  logic signed [25:0] p_term;
  logic signed [25:0] i_step;
  logic signed [25:0] i_next;
  logic signed [25:0] sum;
  logic signed [25:0] lim_s;
  logic tick;

  assign tick = (cnt_q == PWM_MAX - 10'h001);
  assign lim_s = $signed({16'h0000, lp.lim});

  always_comb begin
    err = $signed({1'b0, lp.sp}) - $signed({1'b0, lp.fb});
    kp_s = $signed({1'b0, lp.kp});
    ki_s = $signed({1'b0, lp.ki});
    p_term = (err * kp_s) >>> GAIN_SHIFT;
    i_step = (err * ki_s) >>> GAIN_SHIFT;
    i_next = integ_q + i_step;
    if (i_next < 26'sd0) begin
      i_next = 26'sd0;
    end else if (i_next > lim_s) begin
      i_next = lim_s;
    end
    sum = p_term + i_next;
    if (sum < 26'sd0) begin
      sum = 26'sd0;
    end else if (sum > lim_s) begin
      sum = lim_s;
    end
  end

  // Carrier counter; regulation updates once per PWM period
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      integ_q <= '0;
      duty_q <= '0;
    end else if (!lp.en) begin
      integ_q <= '0;
      duty_q <= '0;
    end else if (tick) begin
      if (lp.closed_loop) begin
        integ_q <= i_next;
        duty_q <= sum[DUTY_W-1:0];
      end else begin
        integ_q <= '0;
        duty_q <= lp.open_duty;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= lp.en && (cnt_q < duty_q);
    end
  end

  assign lp.duty = duty_q;
  assign lp.drive = drive_q;
endmodule : cdoc_pi_pwm

// File: cdoc_top.sv
// Overview of operation
// - Decode modes 0-3, 5-7; code 4 off
// - Modes 5-7 run modes 1-3 and check open load
// - Full command maps to max current
// - Nonzero current command floors at minimum current
// - Full command maps to voltage limit
// - Direct PWM duty never exceeds limit
// - Dither interval 4-200 ms, 2 ms steps
// - Dither alternately adds, subtracts amount in 10 mA
// - Current loop applies proportional gain
// - Current loop applies integral gain
// - Rising current setpoint ramps min-to-max in time
// - Falling current setpoint ramps max-to-min in time
// - Nine channels, each with own settings
// - Open load flagged when pin low while off
// - Command timeout disables drivers, clears commands
`timescale 1ns/1ps
module cdoc_top #(
  parameter int CYC_MS = cdoc_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Avalon-MM slave
  input wire logic [cdoc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Load measurement and pin sense
  input wire logic [cdoc_pkg::NCH*cdoc_pkg::CUR_W-1:0] i_current_fb,
  input wire logic [cdoc_pkg::NCH*cdoc_pkg::VOLT_W-1:0] i_volt_fb,
  input wire logic [cdoc_pkg::NCH-1:0] i_pin_sense,
  // Drive and fault outputs
  output logic [cdoc_pkg::NCH-1:0] o_drive,
  output logic [cdoc_pkg::NCH-1:0] o_open_fault,
  output logic o_command_timeout_fault,
  output logic o_irq
);
  import cdoc_pkg::*;

  localparam logic [31:0] CYC_MS_W = 32'(CYC_MS);
  localparam logic [16:0] CYC_MS_M1 = 17'(CYC_MS - 1);

  // Returns {valid, channel index} for a per-channel address
  function automatic logic [4:0] cdoc_chan_sel(input logic [ADDR_W-1:0] a);
    logic [5:0] slot;
    slot = a[11:6];
    return {(slot != 6'h00) && (slot <= 6'(NCH)), 4'(slot - 6'h01)};
  endfunction : cdoc_chan_sel

  // Returns {valid, open check, base mode}
  function automatic logic [3:0] cdoc_mode_dec(input logic [2:0] m);
    if (m == MODE_UNUSED) begin
      return 4'h0;
    end
    return {1'b1, m[2], m[1:0]};
  endfunction : cdoc_mode_dec

  // Per-channel settings
  logic [2:0] mode_q [NCH];
  logic [CMD_W-1:0] cmd_q [NCH];
  logic [CUR_W-1:0] max_cur_q [NCH];
  logic [CUR_W-1:0] min_cur_q [NCH];
  logic [VOLT_W-1:0] vlim_q [NCH];
  logic [DUTY_W-1:0] pwm_lim_q [NCH];
  logic [6:0] dper_q [NCH];
  logic [5:0] damt_q [NCH];
  logic [GAIN_W-1:0] kp_q [NCH];
  logic [GAIN_W-1:0] ki_q [NCH];
  logic [9:0] rup_q [NCH];
  logic [9:0] rdn_q [NCH];
  logic [DUTY_W-1:0] duty_mon [NCH];

  // Global state
  logic [7:0] timeout_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] irq_en_q;
  logic [ST_W-1:0] status_set;
  logic [NCH-1:0] open_q;
  logic [NCH-1:0] open_set;
  logic [NCH-1:0] pin_s1_q;
  logic [NCH-1:0] pin_s2_q;
  logic [NCH-1:0] drive;
  logic [16:0] ms_cnt_q;
  logic ms_tick;
  logic [9:0] elapsed_q;
  cdoc_to_state_t to_state_q;
  logic fault_enter;
  logic to_fault;
  logic rd_ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_go;
  logic [4:0] wsel;
  logic [4:0] rsel;
  logic cmd_wr;
  logic [10:0] to_limit;

  assign wr_go = i_avs_write && (i_avs_byteenable == 4'hf);
  assign wsel = cdoc_chan_sel(i_avs_address);
  assign rsel = cdoc_chan_sel(i_avs_address);
  assign cmd_wr = wr_go && wsel[4] && (i_avs_address[5:2] == CH_CMD);
  assign to_fault = (to_state_q == TO_FAULT);
  assign to_limit = 11'(timeout_q) * 11'(TIMEOUT_STEP_MS);

  // Avalon: writes complete at once, reads stall one cycle
  assign o_avs_waitrequest = i_avs_read && !rd_ack_q;
  assign o_avs_readdata = rdata_q;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rd_ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      rd_ack_q <= i_avs_read && !rd_ack_q;
      if (i_avs_read && !rd_ack_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_comb begin
    rdata_d = '0;
    if (rsel[4]) begin
      case (i_avs_address[5:2])
        CH_MODE: rdata_d = 32'(mode_q[rsel[3:0]]);
        CH_CMD: rdata_d = 32'(cmd_q[rsel[3:0]]);
        CH_MAX_CUR: rdata_d = 32'(max_cur_q[rsel[3:0]]);
        CH_MIN_CUR: rdata_d = 32'(min_cur_q[rsel[3:0]]);
        CH_VLIM: rdata_d = 32'(vlim_q[rsel[3:0]]);
        CH_PWM_LIM: rdata_d = 32'(pwm_lim_q[rsel[3:0]]);
        CH_DPERIOD: rdata_d = 32'(dper_q[rsel[3:0]]);
        CH_DAMOUNT: rdata_d = 32'(damt_q[rsel[3:0]]);
        CH_KP: rdata_d = 32'(kp_q[rsel[3:0]]);
        CH_KI: rdata_d = 32'(ki_q[rsel[3:0]]);
        CH_RUP: rdata_d = 32'(rup_q[rsel[3:0]]);
        CH_RDN: rdata_d = 32'(rdn_q[rsel[3:0]]);
        CH_DUTY: rdata_d = 32'(duty_mon[rsel[3:0]]);
        default: rdata_d = '0;
      endcase
    end else begin
      case (i_avs_address)
        REG_STATUS: rdata_d = 32'(status_q);
        REG_IRQ_EN: rdata_d = 32'(irq_en_q);
        REG_TIMEOUT: rdata_d = 32'(timeout_q);
        REG_LIVE: rdata_d = {15'h0000, to_fault, 7'h00, open_q};
        default: rdata_d = '0;
      endcase
    end
  end

  // Settings store, one copy per channel
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      for (int k = 0; k < NCH; k++) begin
        mode_q[k] <= RST_MODE;
        max_cur_q[k] <= RST_MAX_CUR;
        min_cur_q[k] <= RST_MIN_CUR;
        vlim_q[k] <= RST_VLIM;
        pwm_lim_q[k] <= RST_PWM_LIM;
        dper_q[k] <= RST_DPERIOD;
        damt_q[k] <= RST_DAMOUNT;
        kp_q[k] <= RST_KP;
        ki_q[k] <= RST_KI;
        rup_q[k] <= RST_RAMP;
        rdn_q[k] <= RST_RAMP;
      end
    end else if (wr_go && wsel[4]) begin
      case (i_avs_address[5:2])
        CH_MODE: mode_q[wsel[3:0]] <= i_avs_writedata[2:0];
        CH_MAX_CUR: max_cur_q[wsel[3:0]] <= i_avs_writedata[11:0];
        CH_MIN_CUR: min_cur_q[wsel[3:0]] <= i_avs_writedata[11:0];
        CH_VLIM: vlim_q[wsel[3:0]] <= i_avs_writedata[9:0];
        CH_PWM_LIM: pwm_lim_q[wsel[3:0]] <= i_avs_writedata[9:0];
        CH_DPERIOD: dper_q[wsel[3:0]] <= i_avs_writedata[6:0];
        CH_DAMOUNT: damt_q[wsel[3:0]] <= i_avs_writedata[5:0];
        CH_KP: kp_q[wsel[3:0]] <= i_avs_writedata[9:0];
        CH_KI: ki_q[wsel[3:0]] <= i_avs_writedata[9:0];
        CH_RUP: rup_q[wsel[3:0]] <= i_avs_writedata[9:0];
        CH_RDN: rdn_q[wsel[3:0]] <= i_avs_writedata[9:0];
        default: ;
      endcase
    end
  end

  // Commands: cleared on timeout, a new write still lands
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      for (int k = 0; k < NCH; k++) begin
        cmd_q[k] <= '0;
      end
    end else begin
      if (fault_enter) begin
        for (int k = 0; k < NCH; k++) begin
          cmd_q[k] <= '0;
        end
      end
      if (cmd_wr) begin
        cmd_q[wsel[3:0]] <= (i_avs_writedata > 32'(CMD_FULL)) ? CMD_FULL :
          i_avs_writedata[CMD_W-1:0];
      end
    end
  end

  // Global registers
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      timeout_q <= RST_TIMEOUT;
      irq_en_q <= '0;
    end else if (wr_go && !wsel[4]) begin
      if (i_avs_address == REG_TIMEOUT) begin
        timeout_q <= i_avs_writedata[7:0];
      end
      if (i_avs_address == REG_IRQ_EN) begin
        irq_en_q <= i_avs_writedata[ST_W-1:0];
      end
    end
  end

  assign status_set = {fault_enter, open_set};

  // Sticky events; a set in the clearing cycle survives
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      status_q <= '0;
    end else if (wr_go && !wsel[4] && (i_avs_address == REG_CLEAR)) begin
      status_q <= (status_q & ~i_avs_writedata[ST_W-1:0]) | status_set;
    end else begin
      status_q <= status_q | status_set;
    end
  end

  assign o_irq = |(status_q & irq_en_q);

  // Millisecond tick
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 17'h00001;
    end
  end

  assign ms_tick = (ms_cnt_q == CYC_MS_M1);

  // Command watchdog
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      to_state_q <= TO_IDLE;
      elapsed_q <= '0;
    end else begin
      if (cmd_wr) begin
        elapsed_q <= '0;
      end else if (ms_tick && (elapsed_q != 10'h3ff)) begin
        elapsed_q <= elapsed_q + 10'h001;
      end
      case (to_state_q)
        TO_IDLE: if (cmd_wr) begin
          to_state_q <= TO_RUN;
        end
        TO_RUN: if (fault_enter) begin
          to_state_q <= TO_FAULT;
        end
        TO_FAULT: if (cmd_wr) begin
          to_state_q <= TO_RUN;
        end
        default: to_state_q <= TO_IDLE;
      endcase
    end
  end

  assign fault_enter = (to_state_q == TO_RUN) && !cmd_wr && (timeout_q != 8'h00) &&
    (11'(elapsed_q) >= to_limit);
  assign o_command_timeout_fault = to_fault;

  // Pin sense synchroniser
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= i_pin_sense;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign o_drive = drive;
  assign o_open_fault = open_q;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    cdoc_loop_if lp();
    logic [3:0] dec;
    logic en;
    logic [22:0] cur_prod;
    logic [11:0] cur_scaled;
    logic [11:0] tgt;
    logic [11:0] sp_q;
    logic [27:0] acc_q;
    logic [11:0] span;
    logic [31:0] thr;
    logic [31:0] acc_sum;
    logic [7:0] dcnt_q;
    logic dsign_q;
    logic [SP_W-1:0] damt_ma;
    logic [SP_W-1:0] cur_sp;
    logic [20:0] volt_prod;
    logic [20:0] pwm_prod;
    logic [DUTY_W-1:0] direct_duty;
    logic [4:0] off_cnt_q;
    logic settled;

    assign dec = cdoc_mode_dec(mode_q[c]);
    assign en = dec[3] && !to_fault;

    // Current target with floor for nonzero commands
    assign cur_prod = 23'(max_cur_q[c]) * 23'(cmd_q[c]);
    assign cur_scaled = cur_prod[21:10];
    assign tgt = (cmd_q[c] == '0) ? '0 :
      (cur_scaled < min_cur_q[c]) ? min_cur_q[c] : cur_scaled;

    // Slew: one mA step each time span accumulates past ramp time
    assign span = (max_cur_q[c] > min_cur_q[c]) ? max_cur_q[c] - min_cur_q[c] : 12'h001;
    assign thr = ((tgt > sp_q) ? 32'(rup_q[c]) : 32'(rdn_q[c])) * CYC_MS_W;
    assign acc_sum = 32'(acc_q) + 32'(span);

    always_ff @(posedge i_clock) begin
      if (i_sys_rst || !en || (dec[1:0] != MODE_CURRENT)) begin
        sp_q <= '0;
        acc_q <= '0;
      end else if (tgt == sp_q) begin
        acc_q <= '0;
      end else if (acc_sum >= thr) begin
        sp_q <= (tgt > sp_q) ? sp_q + 12'h001 : sp_q - 12'h001;
        acc_q <= 28'(acc_sum - thr);
      end else begin
        acc_q <= acc_sum[27:0];
      end
    end

    // Dither sign flips every programmed interval
    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        dcnt_q <= '0;
        dsign_q <= 1'b0;
      end else if (ms_tick) begin
        if (9'(dcnt_q) + 9'h001 >= 9'(dper_q[c]) * 9'(DITHER_STEP_MS)) begin
          dcnt_q <= '0;
          dsign_q <= !dsign_q;
        end else begin
          dcnt_q <= dcnt_q + 8'h01;
        end
      end
    end

    assign damt_ma = SP_W'(damt_q[c]) * SP_W'(DITHER_AMT_STEP_MA);
    assign cur_sp = (sp_q == '0) ? '0 :
      dsign_q ? ((SP_W'(sp_q) > damt_ma) ? SP_W'(sp_q) - damt_ma : '0) :
      SP_W'(sp_q) + damt_ma;

    assign volt_prod = 21'(vlim_q[c]) * 21'(cmd_q[c]);
    assign pwm_prod = 21'(PWM_MAX) * 21'(cmd_q[c]);
    assign direct_duty = (pwm_prod[20:10] > 11'(pwm_lim_q[c])) ? pwm_lim_q[c] :
      pwm_prod[19:10];

    always_comb begin
      lp.en = en;
      lp.closed_loop = 1'b0;
      lp.sp = '0;
      lp.fb = '0;
      lp.kp = kp_q[c];
      lp.ki = ki_q[c];
      lp.lim = PWM_MAX;
      lp.open_duty = '0;
      case (dec[1:0])
        MODE_DIGITAL: begin
          lp.en = en && (cmd_q[c] != '0);
          lp.open_duty = PWM_MAX;
        end
        MODE_CURRENT: begin
          lp.closed_loop = 1'b1;
          lp.sp = cur_sp;
          lp.fb = SP_W'(i_current_fb[c*CUR_W +: CUR_W]);
        end
        MODE_VOLTAGE: begin
          lp.closed_loop = 1'b1;
          lp.sp = SP_W'(volt_prod[20:10]);
          lp.fb = SP_W'(i_volt_fb[c*VOLT_W +: VOLT_W]);
        end
        MODE_PWM: begin
          lp.open_duty = direct_duty;
        end
        default: lp.en = 1'b0;
      endcase
    end

    cdoc_pi_pwm u_pwm (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .lp(lp)
    );

    assign drive[c] = lp.drive;
    assign duty_mon[c] = lp.duty;

    // Open-load check once the pin has settled with the driver off
    always_ff @(posedge i_clock) begin
      if (i_sys_rst || lp.drive) begin
        off_cnt_q <= '0;
      end else if (off_cnt_q != OFF_SETTLE) begin
        off_cnt_q <= off_cnt_q + 5'h01;
      end
    end

    assign settled = (off_cnt_q == OFF_SETTLE);
    assign open_set[c] = dec[3] && dec[2] && settled && !pin_s2_q[c] && !open_q[c];

    always_ff @(posedge i_clock) begin
      if (i_sys_rst || !dec[3] || !dec[2]) begin
        open_q[c] <= 1'b0;
      end else if (settled) begin
        open_q[c] <= !pin_s2_q[c];
      end
    end
  end
endmodule : cdoc_top

// File: cdoc_top_assertions.sv
`timescale 1ns/1ps
module cdoc_top_assertions #(
  parameter int CYC_MS = 100
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Bus
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Outputs
  input wire logic [cdoc_pkg::NCH-1:0] o_drive,
  input wire logic [cdoc_pkg::NCH-1:0] o_open_fault,
  input wire logic o_command_timeout_fault,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  chk_read_wait: assert property ($rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("read wait not one cycle");
  chk_write_nowait: assert property (i_avs_write |-> !o_avs_waitrequest)
    else $error("write stalled");
  chk_wait_cause: assert property (o_avs_waitrequest |-> i_avs_read)
    else $error("wait without read");
  chk_rdata_hold: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data moved");
  chk_reset_quiet: assert property ($fell(i_sys_rst) |->
    o_drive == '0 && o_open_fault == '0 && !o_command_timeout_fault && !o_irq)
    else $error("outputs not quiet after reset");
  chk_fault_off: assert property (o_command_timeout_fault [*2] |-> o_drive == '0)
    else $error("drive during timeout");
  chk_fault_exit: assert property ($fell(o_command_timeout_fault) |->
    $past(i_avs_write))
    else $error("timeout left without command");
  chk_open_off: assert property ((o_open_fault & ~$past(o_open_fault) &
    ($past(o_drive) | $past(o_drive, 8) | $past(o_drive, 16))) == '0)
    else $error("open flagged while driving");
  chk_irq_cause: assert property ($rose(o_irq) |->
    $past(i_avs_write) || o_command_timeout_fault || (|o_open_fault))
    else $error("interrupt without cause");
endmodule : cdoc_top_assertions

bind cdoc_top cdoc_top_assertions #(.CYC_MS(CYC_MS)) u_chk (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_drive(o_drive),
  .o_open_fault(o_open_fault), .o_command_timeout_fault(o_command_timeout_fault), .o_irq(o_irq));

// File: cdoc_coil_model.sv
`timescale 1ns/1ps
module cdoc_coil_model (
  // Clock
  input wire logic i_clock,
  // Drive and open-wire selection
  input wire logic [cdoc_pkg::NCH-1:0] i_drive,
  input wire logic [cdoc_pkg::NCH-1:0] i_open,
  // Measurements
  output logic [cdoc_pkg::NCH*cdoc_pkg::CUR_W-1:0] o_current_fb,
  output logic [cdoc_pkg::NCH*cdoc_pkg::VOLT_W-1:0] o_volt_fb,
  output logic [cdoc_pkg::NCH-1:0] o_pin_sense
);
  import cdoc_pkg::*;
  for (genvar c = 0; c < NCH; c++) begin : g_coil
    logic [999:0] hist_q = '0;
    int on_q = 0;
    always_ff @(posedge i_clock) begin
      hist_q <= {hist_q[998:0], i_drive[c]};
      on_q <= on_q + int'(i_drive[c]) - int'(hist_q[999]);
    end
    // Mean over one PWM period: full duty gives 3 A and 36 V
    assign o_current_fb[c*CUR_W +: CUR_W] = CUR_W'(on_q * 3);
    assign o_volt_fb[c*VOLT_W +: VOLT_W] = VOLT_W'(on_q * 36 / 100);
    // Coil pulls the pin up when off; an open wire falls to the pull-down
    assign o_pin_sense[c] = !i_drive[c] && !i_open[c];
  end
endmodule : cdoc_coil_model

// File: cdoc_top_tb_top.sv
`timescale 1ns/1ps
module cdoc_top_tb_top;
  import cdoc_pkg::*;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [ADDR_W-1:0] i_avs_address = '0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = '0;
  logic [31:0] o_avs_readdata, rdata;
  logic o_avs_waitrequest, o_command_timeout_fault, o_irq;
  logic [NCH*CUR_W-1:0] i_current_fb;
  logic [NCH*VOLT_W-1:0] i_volt_fb;
  logic [NCH-1:0] i_pin_sense, o_drive, o_open_fault;
  logic [NCH-1:0] open_mask = '0;
  int bad_count = 0;
  int num_checks = 0;

  cdoc_top #(.CYC_MS(100)) DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_current_fb(i_current_fb), .i_volt_fb(i_volt_fb),
    .i_pin_sense(i_pin_sense), .o_drive(o_drive), .o_open_fault(o_open_fault),
    .o_command_timeout_fault(o_command_timeout_fault), .o_irq(o_irq));
  cdoc_coil_model u_coil (.i_clock(i_clock), .i_drive(o_drive), .i_open(open_mask),
    .o_current_fb(i_current_fb), .o_volt_fb(i_volt_fb), .o_pin_sense(i_pin_sense));

  initial begin
    forever #5 i_clock = ~i_clock;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do @(posedge i_clock); while (o_avs_waitrequest !== 1'b0);
    rdata = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, '0);
    check(rdata, exp, what);
  endtask : rd_chk

  function automatic logic [11:0] ca(input int c, input logic [3:0] w);
    return 12'(32'h40 * (c + 1) + 32'(w) * 4);
  endfunction : ca

  // Duty register and counted on-cycles of one period must both match
  task automatic duty_chk(input int c, input int exp, input string what);
    int n;
    repeat (2100) @(posedge i_clock);
    rd_chk(ca(c, CH_DUTY), 32'(exp), what);
    n = 0;
    repeat (1000) begin
      @(posedge i_clock);
      n += int'(o_drive[c]);
    end
    check(32'(n), 32'(exp), what);
  endtask : duty_chk

  task automatic level_chk(input logic [2:0] m, input logic [31:0] cmd, input int exp,
                           input bit volt, input string what);
    int got;
    bus(1'b1, ca(2, CH_MODE), 32'(m));
    bus(1'b1, ca(2, CH_CMD), cmd);
    repeat (20000) @(posedge i_clock);
    got = volt ? int'(i_volt_fb[2*VOLT_W +: VOLT_W]) : int'(i_current_fb[2*CUR_W +: CUR_W]);
    num_checks++;
    if (got < exp * 95 / 100 || got > exp * 105 / 100) begin
      bad_count++;
      $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : level_chk

  task automatic t_regs;
    rd_chk(ca(0, CH_MAX_CUR), 32'h3e8, "max current reset");
    rd_chk(ca(4, CH_KI), 32'h00a, "integ_gain reset");
    bus(1'b1, ca(8, CH_KP), 32'h1f4);
    rd_chk(ca(8, CH_KP), 32'h1f4, "kp write");
    rd_chk(ca(0, CH_KP), 32'h064, "kp other channel");
    rd_chk(ca(3, CH_DPERIOD), 32'h002, "dither period reset");
    bus(1'b1, ca(3, CH_DAMOUNT), 32'h032);
    rd_chk(ca(3, CH_DAMOUNT), 32'h032, "dither amount");
    rd_chk(12'h014, 32'h0, "unmapped");
    bus(1'b1, REG_STATUS, 32'h3ff);
    rd_chk(REG_STATUS, 32'h0, "status read only");
  endtask : t_regs

  task automatic t_modes;
    bus(1'b1, ca(0, CH_MODE), 32'h3);
    bus(1'b1, ca(0, CH_PWM_LIM), 32'h12c);
    bus(1'b1, ca(0, CH_CMD), 32'h7ff);
    rd_chk(ca(0, CH_CMD), 32'h400, "command clamp");
    duty_chk(0, 300, "pwm limit");
    bus(1'b1, ca(0, CH_PWM_LIM), 32'h3e8);
    bus(1'b1, ca(0, CH_CMD), 32'h200);
    duty_chk(0, 500, "pwm half");
    bus(1'b1, ca(0, CH_MODE), 32'h0);
    bus(1'b1, ca(0, CH_CMD), 32'h1);
    duty_chk(0, 1000, "digital on");
    bus(1'b1, ca(0, CH_MODE), 32'h4);
    duty_chk(0, 0, "unused mode");
    bus(1'b1, ca(0, CH_MODE), 32'h0);
    bus(1'b1, ca(0, CH_CMD), 32'h0);
    duty_chk(0, 0, "digital off");
  endtask : t_modes

  task automatic t_open;
    open_mask[1] <= 1'b1;
    bus(1'b1, ca(1, CH_MODE), 32'h1);
    repeat (60) @(posedge i_clock);
    check(32'(o_open_fault), 32'h0, "open without check");
    bus(1'b1, ca(1, CH_MODE), 32'h5);
    repeat (60) @(posedge i_clock);
    check(32'(o_open_fault), 32'h002, "open load");
    bus(1'b1, REG_IRQ_EN, 32'h002);
    rd_chk(REG_STATUS, 32'h002, "status open");
    check(32'(o_irq), 32'h1, "irq raised");
    bus(1'b1, REG_CLEAR, 32'h002);
    @(posedge i_clock);
    check(32'(o_irq), 32'h0, "irq cleared");
    open_mask[1] <= 1'b0;
    repeat (60) @(posedge i_clock);
    check(32'(o_open_fault), 32'h0, "load back");
    bus(1'b1, ca(1, CH_MODE), 32'h0);
  endtask : t_open

  task automatic t_current;
    bus(1'b1, ca(2, CH_MIN_CUR), 32'h0c8);
    bus(1'b1, ca(2, CH_KI), 32'h0c8);
    bus(1'b1, ca(2, CH_RUP), 32'h00a);
    bus(1'b1, ca(2, CH_RDN), 32'h00a);
    bus(1'b1, ca(2, CH_VLIM), 32'h078);
    level_chk(3'h1, 32'h400, 1000, 1'b0, "full current");
    level_chk(3'h6, 32'h400, 120, 1'b1, "voltage limit");
    level_chk(3'h1, 32'h001, 200, 1'b0, "min current");
    bus(1'b1, ca(2, CH_MODE), 32'h0);
  endtask : t_current

  task automatic t_timeout;
    bus(1'b1, REG_IRQ_EN, 32'h200);
    bus(1'b1, ca(0, CH_CMD), 32'h1);
    bus(1'b1, REG_TIMEOUT, 32'h1);
    repeat (200) @(posedge i_clock);
    check(32'(o_command_timeout_fault), 32'h0, "timeout early");
    repeat (400) @(posedge i_clock);
    check(32'({o_command_timeout_fault, o_irq, o_drive}), 32'h600, "timeout fault");
    rd_chk(ca(0, CH_CMD), 32'h0, "command cleared");
    rd_chk(REG_LIVE, 32'h10000, "live timeout");
    bus(1'b1, ca(0, CH_CMD), 32'h1);
    repeat (3) @(posedge i_clock);
    check(32'(o_command_timeout_fault), 32'h0, "timeout recovered");
  endtask : t_timeout

  initial begin
    repeat (12) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_regs;
    t_modes;
    t_open;
    t_current;
    t_timeout;
    test_done;
  end

  initial begin
    repeat (100000) @(posedge i_clock);
    bad_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    test_done;
  end
endmodule : cdoc_top_tb_top
